// ==== logic/atom_mode_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "atom_regs.svh"

//
// Contract
// - sample clock is normal polarity when timing bit 3 is 0, inverted when 1
// - timing bits 2-1 delay sample clock by 0, 1/8, 1/4 or 3/8 period
// - timing bit 0 turns the duty cycle stabilizer off or on
// - timing bits 7-4 and output mode bit 7 are ignored
// - output mode bits 6-4 select driver current, code 011 unused
// - output mode bit 3 enables termination and scales current by 1.6
// - output mode bit 2 disables outputs to high impedance
// - output mode bits 1-0 select full-rate CMOS, DDR LVDS or DDR CMOS
// - access is one 16-bit word msb first: r/w, 7-bit address, 8 data
// - software reset clears both registers to 00h, reset bit self-clears
// - a read leaves the register unchanged and ignores serial data bits
//
module atom_mode_regs
(
    // clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    // serial configuration pins
    input  wire logic                   i_cs_n,
    input  wire logic                   i_sck,
    input  wire logic                   i_sdi,
    output logic                        o_sdo_out,
    output logic                        o_sdo_oe_n,
    // timing settings
    output logic                        o_output_clock_invert,
    output logic [1:0]                  o_output_clock_phase_sel,
    output logic                        o_duty_cycle_stabilizer_en,
    // output mode settings
    output logic [2:0]                  o_diff_driver_current_sel,
    output logic                        o_internal_termination_en,
    output logic                        o_output_disable,
    output logic [1:0]                  o_output_format_sel,
    output atom_pkg::atom_current_t     o_driver_current_ua,
    // sample clock pin
    output logic                        o_output_sample_clock,
    output logic                        o_output_sample_clock_oe_n
);
    import atom_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       sck_prev_reg;
    logic       cs_s;
    logic       sck_s;
    logic       sdi_s;
    logic       sck_rise;
    logic       sck_fall;

    // pins are asynchronous; sck must be well below the core clock
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            pin_meta_reg <= 3'h4;                     // idle pins: cs high, sck low, no false frame
            pin_sync_reg <= 3'h4;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= {i_cs_n, i_sck, i_sdi};
            pin_sync_reg <= pin_meta_reg;
            sck_prev_reg <= pin_sync_reg[1];
        end
    end

    assign cs_s     = pin_sync_reg[2];
    assign sck_s    = pin_sync_reg[1];
    assign sdi_s    = pin_sync_reg[0];
    assign sck_rise = sck_s && !sck_prev_reg;
    assign sck_fall = !sck_s && sck_prev_reg;

    // ****************************************************************
    // serial frame and registers
    // ****************************************************************
    atom_state_t state_reg;
    atom_state_t state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    atom_byte_t  out_reg;
    atom_byte_t  out_next;
    logic        reading_reg;
    logic        reading_next;
    atom_byte_t  timing_reg;
    atom_byte_t  timing_next;
    atom_byte_t  mode_reg;
    atom_byte_t  mode_next;
    logic        sdo_oe_n_next;
    logic        commit;
    logic [6:0]  rd_addr;

    // read-back mux; the reset register is write only and reads zero
    function automatic atom_byte_t read_mux(input logic [6:0] addr);
        atom_byte_t v;
        v = 8'h00;
        if (addr == `ATOM_ADDR_TIMING)
            v = timing_reg;
        else if (addr == `ATOM_ADDR_OUT_MODE)
            v = mode_reg;
        return v;
    endfunction

    // a full write word is committed when cs rises, never a read word or a cut-short frame
    assign commit = (state_reg == ATOM_SHIFT) && cs_s && (cnt_reg == `ATOM_WORD_BITS)
                    && !shift_reg[15];
    assign rd_addr = {shift_reg[5:0], sdi_s};

    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        shift_next   = shift_reg;
        out_next     = out_reg;
        reading_next = reading_reg;
        timing_next  = timing_reg;
        mode_next    = mode_reg;
        unique case (state_reg)
            ATOM_IDLE:
            begin
                if (!cs_s)
                begin
                    state_next   = ATOM_SHIFT;
                    cnt_next     = 5'h00;
                    reading_next = 1'b0;
                end
            end
            ATOM_SHIFT:
            begin
                if (cs_s)
                begin
                    state_next   = ATOM_IDLE;
                    reading_next = 1'b0;
                    if (commit)
                    begin
                        if (shift_reg[14:8] == `ATOM_ADDR_SW_RESET)
                        begin
                            if (shift_reg[`ATOM_SW_RESET_BIT])
                            begin
                                timing_next = `ATOM_REG_RESET_VAL;
                                mode_next   = `ATOM_REG_RESET_VAL;
                            end
                        end
                        else if (shift_reg[14:8] == `ATOM_ADDR_TIMING)
                            timing_next = shift_reg[7:0] & `ATOM_TIM_USED_MASK;
                        else if (shift_reg[14:8] == `ATOM_ADDR_OUT_MODE)
                            mode_next = shift_reg[7:0] & `ATOM_OM_USED_MASK;
                    end
                end
                else
                begin
                    // edges past the sixteenth are ignored
                    if (sck_rise && cnt_reg != `ATOM_WORD_BITS)
                    begin
                        shift_next = {shift_reg[14:0], sdi_s};
                        cnt_next   = cnt_reg + 5'h01;
                        if (cnt_reg == `ATOM_ADDR_LAST_BIT && shift_reg[6])
                        begin
                            reading_next = 1'b1;
                            out_next     = read_mux(rd_addr);
                        end
                    end
                    if (sck_fall && reading_reg && cnt_reg >= `ATOM_DATA_FIRST_BIT
                        && cnt_reg < `ATOM_WORD_BITS)
                        out_next = {out_reg[6:0], 1'b0};
                end
            end
        endcase
        // open drain: pull low only for a zero data bit
        sdo_oe_n_next = !(reading_next && !out_next[7]);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            state_reg   <= ATOM_IDLE;
            cnt_reg     <= 5'h00;
            shift_reg   <= 16'h0000;
            out_reg     <= 8'h00;
            reading_reg <= 1'b0;
            timing_reg  <= `ATOM_REG_RESET_VAL;
            mode_reg    <= `ATOM_REG_RESET_VAL;
            o_sdo_oe_n  <= 1'b1;
            o_sdo_out   <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            out_reg     <= out_next;
            reading_reg <= reading_next;
            timing_reg  <= timing_next;
            mode_reg    <= mode_next;
            o_sdo_oe_n  <= sdo_oe_n_next;
            o_sdo_out   <= 1'b0;
        end
    end

    // ****************************************************************
    // field decode
    // ****************************************************************
    atom_current_t cur_base;
    atom_current_t cur_next;

    // undefined code 011 reports zero current
    always_comb
    begin
        unique case (mode_reg[`ATOM_OM_CUR_MSB:`ATOM_OM_CUR_LSB])
            3'h0: cur_base = `ATOM_CUR_3P50;
            3'h1: cur_base = `ATOM_CUR_4P00;
            3'h2: cur_base = `ATOM_CUR_4P50;
            3'h3: cur_base = `ATOM_CUR_UNUSED;
            3'h4: cur_base = `ATOM_CUR_3P00;
            3'h5: cur_base = `ATOM_CUR_2P50;
            3'h6: cur_base = `ATOM_CUR_2P10;
            3'h7: cur_base = `ATOM_CUR_1P75;
        endcase
        if (mode_reg[`ATOM_OM_TERM_BIT])
            cur_next = 13'(({3'h0, cur_base} * `ATOM_TERM_MUL) / `ATOM_TERM_DIV);
        else
            cur_next = cur_base;
    end

    // settings flops mirror the registers one cycle later
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            o_output_clock_invert      <= 1'b0;
            o_output_clock_phase_sel   <= 2'h0;
            o_duty_cycle_stabilizer_en <= 1'b0;
            o_diff_driver_current_sel  <= 3'h0;
            o_internal_termination_en  <= 1'b0;
            o_output_disable           <= 1'b0;
            o_output_format_sel        <= 2'h0;
            o_driver_current_ua        <= 13'h0000;
        end
        else
        begin
            o_output_clock_invert      <= timing_reg[`ATOM_TIM_INV_BIT];
            o_output_clock_phase_sel   <= timing_reg[`ATOM_TIM_PHASE_MSB:`ATOM_TIM_PHASE_LSB];
            o_duty_cycle_stabilizer_en <= timing_reg[`ATOM_TIM_DCS_BIT];
            o_diff_driver_current_sel  <= mode_reg[`ATOM_OM_CUR_MSB:`ATOM_OM_CUR_LSB];
            o_internal_termination_en  <= mode_reg[`ATOM_OM_TERM_BIT];
            o_output_disable           <= mode_reg[`ATOM_OM_OFF_BIT];
            o_output_format_sel        <= mode_reg[`ATOM_OM_FMT_MSB:`ATOM_OM_FMT_LSB];
            o_driver_current_ua        <= cur_next;
        end
    end

    // ****************************************************************
    // sample clock
    // ****************************************************************
    atom_output_sample_clock_gen u_output_sample_clock
    (
        .i_core_clk          (i_core_clk),
        .i_reset_n           (i_reset_n),
        .i_invert            (timing_reg[`ATOM_TIM_INV_BIT]),
        .i_phase             (timing_reg[`ATOM_TIM_PHASE_MSB:`ATOM_TIM_PHASE_LSB]),
        .i_disable           (mode_reg[`ATOM_OM_OFF_BIT]),
        .o_sample_clock      (o_output_sample_clock),
        .o_sample_clock_oe_n (o_output_sample_clock_oe_n)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    a_timing_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (commit && shift_reg[14:8] == `ATOM_ADDR_TIMING)
        |=> timing_reg == ($past(shift_reg[7:0]) & `ATOM_TIM_USED_MASK))
        else $error("timing write not stored");
    a_read_keeps_regs: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_reg == ATOM_SHIFT && shift_reg[15] && cnt_reg == `ATOM_WORD_BITS)
        |=> $stable(timing_reg) && $stable(mode_reg))
        else $error("read changed a register");
    a_sw_reset_clears: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (commit && shift_reg[14:8] == `ATOM_ADDR_SW_RESET && shift_reg[`ATOM_SW_RESET_BIT])
        |=> timing_reg == 8'h00 && mode_reg == 8'h00)
        else $error("software reset did not clear");
    a_unused_bits_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        timing_reg[7:4] == 4'h0 && !mode_reg[7])
        else $error("unused bits stored");
    a_cur_plain_3p5: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (mode_reg[6:3] == 4'h0 && $stable(mode_reg)) |=> o_driver_current_ua == 13'h0dac)
        else $error("driver current code 000 wrong");
    a_cur_term_scaled: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (mode_reg[6:3] == 4'h1 && $stable(mode_reg)) |=> o_driver_current_ua == 13'h15e0)
        else $error("terminated current not scaled");
endmodule
`default_nettype wire

// ==== logic/atom_output_sample_clock_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "atom_regs.svh"

module atom_output_sample_clock_gen
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    // settings
    input  wire logic       i_invert,
    input  wire logic [1:0] i_phase,
    input  wire logic       i_disable,
    // sample clock pin
    output logic            o_sample_clock,
    output logic            o_sample_clock_oe_n
);
    import atom_pkg::*;

    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] rel_cnt;
    logic       clk_next;

    // ****************************************************************
    // phase counter and clock shaping
    // ****************************************************************
    // each phase step is one core cycle, an eighth of the period
    always_comb
    begin
        cnt_next = cnt_reg + 3'h1;
        rel_cnt  = cnt_reg - {1'b0, i_phase};
        clk_next = (rel_cnt < `ATOM_SCLK_HALF) ^ i_invert;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            cnt_reg             <= 3'h0;
            o_sample_clock      <= 1'b0;
            o_sample_clock_oe_n <= 1'b0;
        end
        else
        begin
            cnt_reg             <= cnt_next;
            o_sample_clock      <= clk_next;
            o_sample_clock_oe_n <= i_disable;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // settings may be retuned mid-period, so the rise and fall checks judge only settled settings
    a_clk_phase_rise: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (cnt_reg == {1'b0, i_phase} && !i_invert && $stable(i_phase) && $stable(i_invert))
        |=> o_sample_clock && !$past(o_sample_clock))
        else $error("sample clock rise not at selected phase");
    a_clk_phase_fall: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (cnt_reg == ({1'b0, i_phase} ^ 3'h4) && !i_invert && $stable(i_phase) && $stable(i_invert))
        |=> !o_sample_clock && $past(o_sample_clock))
        else $error("sample clock fall not half a period after rise");
    a_clk_invert_pol: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (cnt_reg == {1'b0, i_phase} && i_invert) |=> !o_sample_clock)
        else $error("sample clock polarity not inverted");
    a_out_hiz_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        i_disable |=> o_sample_clock_oe_n)
        else $error("sample clock driven while outputs disabled");
endmodule
`default_nettype wire

// ==== shared/atom_pkg.sv ====
`default_nettype none
package atom_pkg;
    // serial frame state
    typedef enum logic {ATOM_IDLE, ATOM_SHIFT} atom_state_t;
    typedef logic [7:0]  atom_byte_t;
    typedef logic [12:0] atom_current_t;
endpackage
`default_nettype wire

// ==== shared/atom_regs.svh ====
`ifndef ATOM_REGS_SVH
`define ATOM_REGS_SVH

// ****************************************************************
// register addresses on the serial port
// ****************************************************************
`define ATOM_ADDR_SW_RESET  7'h00
`define ATOM_ADDR_TIMING    7'h02
`define ATOM_ADDR_OUT_MODE  7'h03

// ****************************************************************
// reset values and field layout
// ****************************************************************
`define ATOM_REG_RESET_VAL  8'h00
`define ATOM_SW_RESET_BIT   7
`define ATOM_TIM_INV_BIT    3
`define ATOM_TIM_PHASE_MSB  2
`define ATOM_TIM_PHASE_LSB  1
`define ATOM_TIM_DCS_BIT    0
`define ATOM_TIM_USED_MASK  8'h0f
`define ATOM_OM_CUR_MSB     6
`define ATOM_OM_CUR_LSB     4
`define ATOM_OM_TERM_BIT    3
`define ATOM_OM_OFF_BIT     2
`define ATOM_OM_FMT_MSB     1
`define ATOM_OM_FMT_LSB     0
`define ATOM_OM_USED_MASK   8'h7f

// ****************************************************************
// serial word framing
// ****************************************************************
`define ATOM_WORD_BITS      5'h10
`define ATOM_ADDR_LAST_BIT  5'h07
`define ATOM_DATA_FIRST_BIT 5'h09

// ****************************************************************
// driver current in microamps, termination scale is 8/5
// ****************************************************************
`define ATOM_CUR_3P50       13'h0dac
`define ATOM_CUR_4P00       13'h0fa0
`define ATOM_CUR_4P50       13'h1194
`define ATOM_CUR_3P00       13'h0bb8
`define ATOM_CUR_2P50       13'h09c4
`define ATOM_CUR_2P10       13'h0834
`define ATOM_CUR_1P75       13'h06d6
`define ATOM_CUR_UNUSED     13'h0000
`define ATOM_TERM_MUL       16'h0008
`define ATOM_TERM_DIV       16'h0005

// ****************************************************************
// sample clock: eight core cycles a period, high for four
// ****************************************************************
`define ATOM_SCLK_HALF      3'h4

`endif

// ==== tb/atom_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// serial configuration host
// ****************************************************************
module atom_host_model
(
    // clock
    input  wire logic i_core_clk,
    // serial pins
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    // idle pins at time zero, sck stands still outside frames
    initial
    begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_sdi  = 1'b0;
    end

    // one frame of nbits, msb first; half sets sck speed in core cycles (>= 5)
    task automatic xfer(input logic [15:0] word, input int nbits, input int half, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        for (i = 15; i > 15 - nbits; i--)
        begin
            o_sdi <= word[i];
            repeat (half) @(posedge i_core_clk);
            o_sck <= 1'b1;
            if (i < 8)
                rd[i] = i_sdo;
            repeat (half) @(posedge i_core_clk);
            o_sck <= 1'b0;
        end
        repeat (half) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        // no stale data bit left on the line between frames
        o_sdi  <= ~o_sdi;
        repeat (8) @(posedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/atom_mode_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// mode register bench
// ****************************************************************
module atom_mode_regs_tb;
    import atom_pkg::*;

    logic          core_clk;
    logic          reset_n;
    logic          cs_n;
    logic          sck;
    logic          sdi;
    logic          sdo_out;
    logic          sdo_oe_n;
    logic          sdo_line;
    logic          clk_inv;
    logic [1:0]    phase;
    logic          duty_cycle_stabilizer_en;
    logic [2:0]    cur_sel;
    logic          term;
    logic          off;
    logic [1:0]    fmt;
    atom_current_t ua;
    logic          sclk;
    logic          sclk_oe_n;
    int            cyc;
    int            errors;
    int            checks;

    // pull-up on the open-drain data line
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;

    // 10 MHz core clock and cycle count
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    atom_mode_regs atom_mode_regs_i
    (
        .i_core_clk                 (core_clk),
        .i_reset_n                  (reset_n),
        .i_cs_n                     (cs_n),
        .i_sck                      (sck),
        .i_sdi                      (sdi),
        .o_sdo_out                  (sdo_out),
        .o_sdo_oe_n                 (sdo_oe_n),
        .o_output_clock_invert      (clk_inv),
        .o_output_clock_phase_sel   (phase),
        .o_duty_cycle_stabilizer_en (duty_cycle_stabilizer_en),
        .o_diff_driver_current_sel  (cur_sel),
        .o_internal_termination_en  (term),
        .o_output_disable           (off),
        .o_output_format_sel        (fmt),
        .o_driver_current_ua        (ua),
        .o_output_sample_clock      (sclk),
        .o_output_sample_clock_oe_n (sclk_oe_n)
    );

    atom_host_model atom_host_model_i
    (
        .i_core_clk (core_clk),
        .o_cs_n     (cs_n),
        .o_sck      (sck),
        .o_sdi      (sdi),
        .i_sdo      (sdo_line)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic stop_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        atom_host_model_i.xfer({1'b0, a, d}, 16, 5, r);
    endtask

    // slow sck here; data bits on sdi are all ones and must be ignored
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        atom_host_model_i.xfer({1'b1, a, 8'hff}, 16, 9, d);
    endtask

    // core cycle (mod 8) of the second sample clock rise, so a retune glitch is skipped
    task automatic rise_pos(output int pos);
        int  n;
        logic prev;
        pos = -1;
        @(posedge core_clk);
        #1;
        prev = sclk;
        for (n = 0; n < 24 && pos < 8; n++)
        begin
            @(posedge core_clk);
            #1;
            if (!prev && sclk)
                pos = (pos < 0) ? 0 : 8 + cyc % 8;
            prev = sclk;
        end
        if (pos < 8)
        begin
            errors++;
            stop_test();
        end
        pos = pos - 8;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [7:0] r;
        check("sdo_oe_n", sdo_oe_n, 1'b1);
        check("settings", {clk_inv, phase, duty_cycle_stabilizer_en, cur_sel, term, off, fmt}, 16'h0000);
        rd(7'h02, r);
        check("tim_rst", r, 8'h00);
        rd(7'h03, r);
        check("mode_rst", r, 8'h00);
    endtask

    task automatic t_timing();
        logic [7:0] r;
        wr(7'h02, 8'hfb);
        check("invert", clk_inv, 1'b1);
        check("phase", phase, 2'b01);
        check("dcs_on", duty_cycle_stabilizer_en, 1'b1);
        rd(7'h02, r);
        check("tim_rd", r, 8'h0b);
        wr(7'h02, 8'hf8);
        check("dcs_off", duty_cycle_stabilizer_en, 1'b0);
    endtask

    task automatic t_phase();
        int r0;
        int r;
        int p;
        wr(7'h02, 8'h00);
        rise_pos(r0);
        for (p = 0; p < 4; p++)
        begin
            // stabilizer kept on whenever a delay is chosen
            wr(7'h02, {5'h00, p[1:0], 1'b1});
            rise_pos(r);
            check("delay", 16'((r - r0 + 8) % 8), 16'(p));
            wr(7'h02, {5'h01, p[1:0], 1'b1});
            rise_pos(r);
            check("inv_delay", 16'((r - r0 + 8) % 8), 16'((p + 4) % 8));
        end
    endtask

    task automatic t_mode();
        logic [12:0] base [8] = '{13'h0dac, 13'h0fa0, 13'h1194, 13'h0000, 13'h0bb8, 13'h09c4, 13'h0834, 13'h06d6};
        logic [7:0]  d;
        logic [7:0]  r;
        logic [1:0]  f;
        int          c;
        int          t;
        for (c = 0; c < 8; c++)
            for (t = 0; t < 2; t++)
                // unused current and format codes are never written
                if (c != 3)
                begin
                    f = 2'(c % 3);
                    d = {1'b1, c[2:0], t[0], 1'b0, f};
                    wr(7'h03, d);
                    check("cur_sel", cur_sel, c[2:0]);
                    check("term", term, t[0]);
                    check("format", fmt, f);
                    check("enabled", off, 1'b0);
                    check("ua", ua, t ? 16'(base[c]) * 16'h0008 / 16'h0005 : 16'(base[c]));
                end
        rd(7'h03, r);
        check("mode_rd", r, d & 8'h7f);
    endtask

    task automatic t_disable();
        wr(7'h03, 8'h04);
        check("off", off, 1'b1);
        check("hiz", sclk_oe_n, 1'b1);
        wr(7'h03, 8'h00);
        check("driven", sclk_oe_n, 1'b0);
    endtask

    task automatic t_access();
        logic [7:0] r;
        wr(7'h02, 8'h05);
        rd(7'h02, r);
        check("rd_val", r, 8'h05);
        check("rd_keep", {phase, duty_cycle_stabilizer_en}, 3'b101);
        atom_host_model_i.xfer({1'b0, 7'h02, 8'h0e}, 10, 5, r);
        check("short", {phase, duty_cycle_stabilizer_en}, 3'b101);
        wr(7'h05, 8'h5a);
        rd(7'h05, r);
        check("unmapped", r, 8'h00);
        rd(7'h02, r);
        check("kept", r, 8'h05);
    endtask

    task automatic t_swreset();
        logic [7:0] r;
        wr(7'h03, 8'h3a);
        wr(7'h00, 8'h80);
        check("sw_clr", {clk_inv, phase, duty_cycle_stabilizer_en, cur_sel, term, off, fmt}, 16'h0000);
        rd(7'h03, r);
        check("mode_clr", r, 8'h00);
        rd(7'h00, r);
        check("rst_bit", r, 8'h00);
        wr(7'h02, 8'h01);
        rd(7'h02, r);
        check("after_rst", r, 8'h01);
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial
    begin
        reset_n = 1'b0;
        cyc     = 0;
        errors  = 0;
        checks  = 0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_timing();
        t_phase();
        t_mode();
        t_disable();
        t_access();
        t_swreset();
        stop_test();
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (90000) @(posedge core_clk);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
